// ### hdl/mvees_pkg.sv
package mvees_pkg;
  // ==========================================================
  // Event codes
  localparam logic [7:0] EV_FILL_MAIN = 8'h90;
  localparam logic [7:0] EV_FILL_ALT = 8'h91;
  localparam logic [7:0] EV_ALLOC_MAIN = 8'h92;
  localparam logic [7:0] EV_ALLOC_ALT = 8'h93;
  localparam logic [7:0] EV_FULL_MAIN = 8'h94;
  localparam logic [7:0] EV_FULL_ALT = 8'h95;
  localparam logic [7:0] EV_NONEMPTY_MAIN = 8'h96;
  localparam logic [7:0] EV_NONEMPTY_ALT = 8'h97;
  localparam logic [7:0] EV_REJECT_MAIN = 8'h98;
  localparam logic [7:0] EV_REJECT_ALT = 8'h99;
  localparam logic [7:0] EV_STARVE_MAIN = 8'h9A;
  localparam logic [7:0] EV_SKIP_ALT = 8'h9E;
  // ==========================================================
  // Queue indices: 0..6 main classes, 7 ack-c agent0, 8 ack-c agent1
  localparam int NQ = 9;
  localparam int NMAIN = 7;
  localparam int Q_ACKC0 = 7;
  localparam int Q_ACKC1 = 8;
  localparam int OCC_W = 6;
  localparam int SUM_W = 10;
  localparam int STARVE_W = 8;
  localparam logic [7:0] STARVE_THRESH_RST = 8'h40;
  localparam logic [7:0] UMASK_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;
  // ==========================================================
  // Control field positions
  localparam int CODE_LSB = 0;
  localparam int UMASK_LSB = 8;
  localparam int CTRL_W = 16;
endpackage

// ### hdl/mvees_select.sv
`timescale 1ns/1ps
`default_nettype none
module mvees_select
  import mvees_pkg::*;
(
  input wire logic ref_clk, // Mesh clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic [CTRL_W-1:0] ctrl_in, // Code [7:0], unit mask [15:8]
  input wire logic ctrl_wr, // Load control
  input wire logic [STARVE_W-1:0] starve_thresh, // Starvation run length
  input wire logic [NQ-1:0] q_full, // Per queue full
  input wire logic [NQ*OCC_W-1:0] q_occ, // Per queue entry counts
  input wire logic [NQ-1:0] q_alloc, // Per queue allocation pulse
  input wire logic [NQ-1:0] q_reject, // Per queue reject pulse
  input wire logic [NQ-1:0] q_inject_fail, // Per queue injection failed
  input wire logic [1:0] ackc_skip, // Ack-c bypass pulses, agent 0/1
  output logic [SUM_W-1:0] count_inc, // Increment this cycle
  output logic [CTRL_W-1:0] ctrl_out, // Current control
  output logic [NQ-1:0] starved // Per queue starvation
);

  logic [7:0] code_ff;
  logic [7:0] umask_ff;
  logic [NQ-1:0] sel;
  logic [NQ-1:0] is_main;
  logic [NQ-1:0] skip_vec;
  logic [NQ*OCC_W-1:0] term_flat;
  logic [SUM_W-1:0] nxt_inc;
  logic [SUM_W-1:0] inc_ff;
  logic main_class;
  logic alt_class;
  logic vert_egress_fill_main_event;
  logic vert_egress_fill_alt_event;
  logic vert_egress_alloc_main_event;
  logic vert_egress_alloc_alt_event;
  logic vert_egress_full_main_event;
  logic vert_egress_full_alt_event;
  logic vert_egress_nonempty_main_event;
  logic vert_egress_nonempty_alt_event;
  logic vert_egress_reject_main_event;
  logic vert_egress_reject_alt_event;
  logic vert_egress_starve_main_event;
  logic vert_egress_skip_alt_event;
  logic request_agent0_sel;
  logic acknowledge_agent0_sel;
  logic data_agent0_sel;
  logic snoop_agent0_sel;
  logic request_agent1_sel;
  logic acknowledge_agent1_sel;
  logic data_agent1_sel;
  logic ack_c_agent0_sel;
  logic ack_c_agent1_sel;

  // ==========================================================
  // Control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      code_ff <= CODE_RST;
      umask_ff <= UMASK_RST;
    end else if (ctrl_wr) begin
      code_ff <= ctrl_in[CODE_LSB +: 8];
      umask_ff <= ctrl_in[UMASK_LSB +: 8];
    end
  end

  // ==========================================================
  // Event code decode
  // Each measure has a main and an alternate code, except starve (main only) and skip (alternate only)
  assign vert_egress_fill_main_event = (code_ff == EV_FILL_MAIN);
  assign vert_egress_fill_alt_event = (code_ff == EV_FILL_ALT);
  assign vert_egress_alloc_main_event = (code_ff == EV_ALLOC_MAIN);
  assign vert_egress_alloc_alt_event = (code_ff == EV_ALLOC_ALT);
  assign vert_egress_full_main_event = (code_ff == EV_FULL_MAIN);
  assign vert_egress_full_alt_event = (code_ff == EV_FULL_ALT);
  assign vert_egress_nonempty_main_event = (code_ff == EV_NONEMPTY_MAIN);
  assign vert_egress_nonempty_alt_event = (code_ff == EV_NONEMPTY_ALT);
  assign vert_egress_reject_main_event = (code_ff == EV_REJECT_MAIN);
  assign vert_egress_reject_alt_event = (code_ff == EV_REJECT_ALT);
  assign vert_egress_starve_main_event = (code_ff == EV_STARVE_MAIN);
  assign vert_egress_skip_alt_event = (code_ff == EV_SKIP_ALT);

  // Codes that read the seven-queue main mask layout
  assign main_class = vert_egress_fill_main_event || vert_egress_alloc_main_event ||
    vert_egress_full_main_event || vert_egress_nonempty_main_event ||
    vert_egress_reject_main_event || vert_egress_starve_main_event;
  // Codes that read only the two acknowledge-c mask bits
  assign alt_class = vert_egress_fill_alt_event || vert_egress_alloc_alt_event ||
    vert_egress_full_alt_event || vert_egress_nonempty_alt_event ||
    vert_egress_reject_alt_event || vert_egress_skip_alt_event;

  // ==========================================================
  // Queue select from unit mask
  // Unknown codes select nothing, so they can never count
  // main mask layout
  assign request_agent0_sel = main_class && umask_ff[0];
  assign acknowledge_agent0_sel = main_class && umask_ff[1];
  assign data_agent0_sel = main_class && umask_ff[2];
  assign snoop_agent0_sel = main_class && umask_ff[3];
  assign request_agent1_sel = main_class && umask_ff[4];
  assign acknowledge_agent1_sel = main_class && umask_ff[5];
  assign data_agent1_sel = main_class && umask_ff[6];
  // Bit 15 has no queue behind it and is dropped
  // ack-c agent bits
  assign ack_c_agent0_sel = alt_class && umask_ff[0];
  assign ack_c_agent1_sel = alt_class && umask_ff[1];
  assign sel = {ack_c_agent1_sel, ack_c_agent0_sel, data_agent1_sel, acknowledge_agent1_sel,
    request_agent1_sel, snoop_agent0_sel, data_agent0_sel, acknowledge_agent0_sel,
    request_agent0_sel};

  // ==========================================================
  // Per-queue side inputs
  // ack-c bypass pulses
  assign skip_vec = {ackc_skip, {NMAIN{1'b0}}};

  // ==========================================================
  // Per-queue contribution
  // Amount one selected queue adds for the live code
  function automatic logic [OCC_W-1:0] measure_term(
    input logic [7:0] code,
    input logic [OCC_W-1:0] occ,
    input logic full,
    input logic alloc,
    input logic reject,
    input logic starve,
    input logic skip
  );
    measure_term = '0;
    unique case (code)
      EV_FILL_MAIN, EV_FILL_ALT: begin
        measure_term = occ;
      end
      EV_ALLOC_MAIN, EV_ALLOC_ALT: begin
        measure_term = OCC_W'(alloc);
      end
      EV_FULL_MAIN, EV_FULL_ALT: begin
        measure_term = OCC_W'(full);
      end
      EV_NONEMPTY_MAIN, EV_NONEMPTY_ALT: begin
        measure_term = OCC_W'(occ != '0);
      end
      EV_REJECT_MAIN, EV_REJECT_ALT: begin
        measure_term = OCC_W'(reject);
      end
      EV_STARVE_MAIN: begin
        measure_term = OCC_W'(starve);
      end
      EV_SKIP_ALT: begin
        measure_term = OCC_W'(skip);
      end
      default: begin
        measure_term = '0;
      end
    endcase
  endfunction

  // ==========================================================
  // Starvation run counters and per-queue terms
  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_queue
      logic [STARVE_W-1:0] run_ff;
      // run threshold
      // Run saturates so a long stall never wraps back to zero
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          run_ff <= '0;
        end else if (!q_inject_fail[g]) begin
          run_ff <= '0;
        end else if (run_ff != {STARVE_W{1'b1}}) begin
          run_ff <= STARVE_W'(run_ff + 1'b1);
        end
      end
      assign starved[g] = q_inject_fail[g] && (run_ff >= starve_thresh);
      assign is_main[g] = (g < NMAIN);
      assign term_flat[g*OCC_W +: OCC_W] = sel[g] ?
        measure_term(code_ff, q_occ[g*OCC_W +: OCC_W], q_full[g], q_alloc[g], q_reject[g],
          starved[g] && is_main[g], skip_vec[g]) : '0;
    end
  endgenerate

  // ==========================================================
  // Sum of selected queues
  // sum selected sources
  // Nine full six-bit counts still fit the ten-bit sum
  always_comb begin
    nxt_inc = '0;
    for (int i = 0; i < NQ; i++) begin
      nxt_inc = nxt_inc + SUM_W'(term_flat[i*OCC_W +: OCC_W]);
    end
  end

  // ==========================================================
  // Registered outputs
  // Increment lags its cause by one edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      inc_ff <= '0;
    end else begin
      inc_ff <= nxt_inc;
    end
  end

  assign count_inc = inc_ff;
  assign ctrl_out = {umask_ff, code_ff};

endmodule
`default_nettype wire

// ### verif/mvees_queues.sv
`timescale 1ns/1ps
`default_nettype none
module mvees_queues
  import mvees_pkg::*;
#(parameter int DEPTH = 4)
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [NQ-1:0] push, // Enqueue
  input wire logic [NQ-1:0] block, // Ring refuses
  output logic [NQ*OCC_W-1:0] q_occ, // Counts
  output logic [NQ-1:0] q_full, // At depth
  output logic [NQ-1:0] q_alloc, // Accepted
  output logic [NQ-1:0] q_inject_fail // Stuck head
);
  logic [OCC_W-1:0] occ_ff [NQ];
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NQ; i++) begin
      if (sys_rst) occ_ff[i] <= '0;
      else if (q_alloc[i]) occ_ff[i] <= occ_ff[i] + 1'b1;
    end
  end
  // Status seen by the selector
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      q_occ[i*OCC_W +: OCC_W] = occ_ff[i];
      q_full[i] = occ_ff[i] == OCC_W'(DEPTH);
      q_alloc[i] = push[i] && !q_full[i];
      q_inject_fail[i] = block[i] && occ_ff[i] != '0;
    end
  end
endmodule
`default_nettype wire

// ### verif/mvees_select_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mvees_select_asserts
  import mvees_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [CTRL_W-1:0] ctrl_out, // Control
  input wire logic [NQ-1:0] q_full, // Full
  input wire logic [NQ*OCC_W-1:0] q_occ, // Counts
  input wire logic [NQ-1:0] q_alloc, // Alloc
  input wire logic [NQ-1:0] q_reject, // Reject
  input wire logic [1:0] ackc_skip, // Skip
  input wire logic [SUM_W-1:0] count_inc, // Increment
  input wire logic [NQ-1:0] starved // Starve
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Increment against selected cause
  a_null_code: assert property (ctrl_out[7:0] == 8'h00 |=> count_inc == '0)
    else $error("null code counted");
  a_nonempty_pair: assert property (ctrl_out == 16'h0396 |=>
    count_inc == 10'($past($countones({q_occ[11:6] != '0, q_occ[5:0] != '0}))))
    else $error("nonempty sum");
  a_alloc_main: assert property (ctrl_out[7:0] == 8'h92 |=>
    count_inc == 10'($past($countones(q_alloc[6:0] & ctrl_out[14:8]))))
    else $error("alloc sum");
  a_full_alt: assert property (ctrl_out == 16'h0295 |=> count_inc == {9'h0, $past(q_full[8])})
    else $error("full alt");
  a_fill_alt: assert property (ctrl_out == 16'h0391 |=>
    count_inc == $past(q_occ[47:42]) + $past(q_occ[53:48]))
    else $error("fill alt");
  a_reject_alt: assert property (ctrl_out[7:0] == 8'h99 |=>
    count_inc == 10'($past($countones(q_reject[8:7] & ctrl_out[9:8]))))
    else $error("reject alt");
  a_skip_alt: assert property (ctrl_out == 16'h029e |=> count_inc == {9'h0, $past(ackc_skip[1])})
    else $error("skip alt");
  a_starve_snoop: assert property (ctrl_out == 16'h089a |=> count_inc == {9'h0, $past(starved[3])})
    else $error("starve snoop");
endmodule
bind mvees_select mvees_select_asserts mvees_select_asserts_i (.ref_clk, .sys_rst, .ctrl_out,
  .q_full, .q_occ, .q_alloc, .q_reject, .ackc_skip, .count_inc, .starved);
`default_nettype wire

// ### verif/mvees_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mvees_select_tb;
  import mvees_pkg::*;
  logic ref_clk = 0, sys_rst = 1, ctrl_wr = 0;
  logic [CTRL_W-1:0] ctrl_in = '0, ctrl_out;
  logic [STARVE_W-1:0] starve_thresh = 8'h03;
  logic [NQ-1:0] push = '0, block = '0, q_reject = '0, q_full, q_alloc, q_inject_fail, starved;
  logic [NQ*OCC_W-1:0] q_occ;
  logic [1:0] ackc_skip = '0;
  logic [SUM_W-1:0] count_inc;
  int fail_count = 0, num_checks = 0, cycles = 0;
  // ==========================================================
  // Clock, timeout and instances
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 300) begin
      fail_count++;
      print_verdict;
    end
  end
  mvees_queues mvees_queues_i (.ref_clk, .sys_rst, .push, .block, .q_occ, .q_full, .q_alloc,
    .q_inject_fail);
  mvees_select mvees_select_i (.ref_clk, .sys_rst, .ctrl_in, .ctrl_wr, .starve_thresh, .q_full,
    .q_occ, .q_alloc, .q_reject, .q_inject_fail, .ackc_skip, .count_inc, .ctrl_out, .starved);
  // Edge then settle
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  // Load control for one edge
  task wr(input logic [CTRL_W-1:0] v);
    ctrl_in = v;
    ctrl_wr = 1;
    tick;
    ctrl_wr = 0;
  endtask
  task check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) tick;
    sys_rst = 0;
    check(ctrl_out, '0);
    wr(16'hff92);
    check(ctrl_out, 16'hff92);
    push = 9'h1ff;
    tick;
    push = '0;
    check(count_inc, 16'h0007);
    wr(16'h0396);
    tick;
    check(count_inc, 16'h0002);
    push = 9'h100;
    repeat (4) tick;
    push = '0;
    wr(16'h0295);
    tick;
    check(count_inc, 16'h0001);
    wr(16'h0391);
    tick;
    check(count_inc, 16'h0005);
    wr(16'h0399);
    q_reject = 9'h180;
    tick;
    q_reject = '0;
    check(count_inc, 16'h0002);
    wr(16'h029e);
    ackc_skip = 2'b11;
    tick;
    ackc_skip = '0;
    check(count_inc, 16'h0001);
    wr(16'hffa0);
    q_reject = '1;
    tick;
    q_reject = '0;
    check(count_inc, '0);
    block = 9'h008;
    wr(16'h089a);
    repeat (5) tick;
    check(starved, 16'h0008);
    check(count_inc, 16'h0001);
    block = '0;
    tick;
    check(starved, '0);
    wr(16'h7f90);
    tick;
    check(count_inc, 16'h0007);
    wr(16'h0193);
    push = 9'h180;
    tick;
    push = '0;
    check(count_inc, 16'h0001);
    push = 9'h040;
    wr(16'h6094);
    repeat (2) tick;
    push = '0;
    tick;
    check(count_inc, 16'h0001);
    wr(16'h0297);
    tick;
    check(count_inc, 16'h0001);
    wr(16'h2198);
    q_reject = '1;
    tick;
    q_reject = '0;
    check(count_inc, 16'h0002);
    print_verdict;
  end
endmodule
`default_nettype wire
